// ==== ccp_pkg.sv ====
// Shared constants and types of the codec control port.
// How it works
// - After every pair of data bytes in a multi-byte access the register address steps up by one.
// - A start or stop seen on the bus ends whatever command is in progress.
// - A read that follows a new start without a fresh address continues from the current address.
// - A single write is start, device address with write, two address bytes, two data bytes, stop, each acknowledged.
// - A single read writes the address, restarts with read, returns high then low byte, the master nacks the last.
// - An auto-increment read returns the addressed register and then each following one until the master nacks.
// - In serial-peripheral mode the port is a slave using the shared pin as active-low select, clock and data in.
// - The serial-peripheral mode accepts writes only and never drives the data line.
// - When select rises the last 32 bits shifted in give the address (upper half) and the value (lower half).
// - Line output, headphone output and serial audio output stay muted after reset until software unmutes them.
// - Every register has a 16-bit address and 16 bits of data, sent most significant byte first.
// - The port answers the 7-bit address 0n01010 where n is the level of the shared address/select pin.
// - The mode pin low selects the two-wire bus and high selects the serial-peripheral bus.
package ccp_pkg;
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 16;
    localparam int          SPI_FRAME    = 32;
    localparam logic [5:0]  DEV_ADDR_LOW = 6'h0A;
    localparam int          MEM_DEPTH    = 256;
    localparam int          MEM_AW       = 8;
    localparam logic [15:0] MUTE_REG     = 16'h0024;
    localparam int          MUTE_HP_BIT  = 4;
    localparam int          MUTE_LO_BIT  = 8;
    localparam int          MUTE_I2S_BIT = 0;
    localparam logic [15:0] MUTE_RESET   = 16'h0111;

    typedef enum logic [3:0] {
        ST_IDLE, ST_DEVADR, ST_DEVACK, ST_ADRHI, ST_ADRLO, ST_WRHI, ST_WRLO, ST_RDHI, ST_RDLO,
        ST_BYTEACK, ST_MACK, ST_IGNORE
    } tw_state_t;

    function automatic logic [15:0] inc_addr(input logic [15:0] a);
        inc_addr = a + 16'h0001;
    endfunction : inc_addr
endpackage : ccp_pkg

// ==== reg_bus_if.sv ====
// Internal register write and read bus between the control port and its memory.
`timescale 1ns/1ps
interface reg_bus_if;
    logic        wr_en;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_addr;
    logic [15:0] rd_data;
    modport master (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport slave  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : reg_bus_if

// ==== reg_mem.sv ====
// Small register memory with registered read data.
`timescale 1ns/1ps
module reg_mem
    import ccp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic ce,
    reg_bus_if.slave  bus
);
    logic [15:0] mem_ff [MEM_DEPTH];
    logic [15:0] rd_ff;
    wire  [MEM_AW-1:0] wa = bus.wr_addr[MEM_AW-1:0];
    wire  [MEM_AW-1:0] ra = bus.rd_addr[MEM_AW-1:0];

    // No reset on the array keeps it a plain memory; the mute word is held by the top instead.
    always_ff @(posedge ref_clk) begin
        if (ce && bus.wr_en) begin
            mem_ff[wa] <= bus.wr_data;
        end
        if (ce) begin
            rd_ff <= mem_ff[ra];
        end
    end
    assign bus.rd_data = rd_ff;
endmodule : reg_mem

// ==== spi_rx.sv ====
// Write-only serial-peripheral receiver working on oversampled pins.
`timescale 1ns/1ps
module spi_rx
    import ccp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        active,
    input  wire logic        sck_s,
    input  wire logic        mosi_s,
    input  wire logic        ss_n_s,
    output logic             frame_valid,
    output logic [15:0]      frame_addr,
    output logic [15:0]      frame_data
);
    logic [31:0] shift_ff;
    logic [5:0]  cnt_ff;
    logic        sck_d_ff;
    logic        ss_d_ff;
    wire         sck_rise = sck_s & ~sck_d_ff;
    wire         ss_rise  = ss_n_s & ~ss_d_ff;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff    <= 32'h00000000;
            cnt_ff      <= 6'h00;
            sck_d_ff    <= 1'b0;
            ss_d_ff     <= 1'b1;
            frame_valid <= 1'b0;
            frame_addr  <= 16'h0000;
            frame_data  <= 16'h0000;
        end else if (ce) begin
            sck_d_ff    <= sck_s;
            ss_d_ff     <= ss_n_s;
            frame_valid <= 1'b0;
            if (!active || ss_n_s) begin
                cnt_ff <= 6'h00;
            end else if (sck_rise) begin
                shift_ff <= {shift_ff[30:0], mosi_s};
                if (cnt_ff != 6'h20) begin
                    cnt_ff <= cnt_ff + 6'h01;
                end
            end
            if (active && ss_rise && cnt_ff == 6'(SPI_FRAME)) begin
                frame_valid <= 1'b1;
                frame_addr  <= shift_ff[31:16];
                frame_data  <= shift_ff[15:0];
            end
        end
    end
endmodule : spi_rx

// ==== codec_control_port.sv ====
// Top of the codec control port: two-wire slave, serial-peripheral receiver and mute state.
`timescale 1ns/1ps
module codec_control_port
    import ccp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic mode_pin,
    input  wire logic ctrl_clk_pin,
    input  wire logic ctrl_data_in,
    output logic      ctrl_data_out,
    output logic      ctrl_data_oe,
    input  wire logic addr_bit_or_slave_select_pin,
    output logic      line_level_output_mute,
    output logic      headphone_output_mute,
    output logic      serial_audio_out_mute
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [1:0] scl_sy_ff, sda_sy_ff, sel_sy_ff, mode_sy_ff;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_sy_ff  <= 2'h3;
            sda_sy_ff  <= 2'h3;
            sel_sy_ff  <= 2'h3;
            mode_sy_ff <= 2'h0;
        end else if (ce) begin
            scl_sy_ff  <= {scl_sy_ff[0], ctrl_clk_pin};
            sda_sy_ff  <= {sda_sy_ff[0], ctrl_data_in};
            sel_sy_ff  <= {sel_sy_ff[0], addr_bit_or_slave_select_pin};
            mode_sy_ff <= {mode_sy_ff[0], mode_pin};
        end
    end
    wire scl = scl_sy_ff[1];
    wire sda = sda_sy_ff[1];
    wire sel = sel_sy_ff[1];
    wire spi_mode = mode_sy_ff[1];

    reg_bus_if bus ();
    reg_mem reg_mem_inst (.ref_clk(ref_clk), .ce(ce), .bus(bus));

    logic        spi_valid;
    logic [15:0] spi_addr, spi_data;
    spi_rx spi_rx_inst (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .ce         (ce),
        .active     (spi_mode),
        .sck_s      (scl),
        .mosi_s     (sda),
        .ss_n_s     (sel),
        .frame_valid(spi_valid),
        .frame_addr (spi_addr),
        .frame_data (spi_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two-wire bus conditions.
    logic scl_d_ff, sda_d_ff;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else if (ce) begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
        end
    end
    wire scl_rise  = scl & ~scl_d_ff;
    wire scl_fall  = ~scl & scl_d_ff;
    wire start_det = scl & scl_d_ff & sda_d_ff & ~sda & ~spi_mode;
    wire stop_det  = scl & scl_d_ff & ~sda_d_ff & sda & ~spi_mode;

    tw_state_t   st_ff, ret_ff;
    logic [7:0]  sh_ff;
    logic [2:0]  bit_ff;
    logic [15:0] addr_ff;
    logic [7:0]  ahi_ff, dhi_ff;
    logic        rnw_ff;
    logic        drv_ff;
    logic        wr_ff;
    logic [15:0] wdat_ff;
    logic [15:0] rbuf_ff;

    wire       addr_hit = sh_ff[7:1] == {1'b0, sel, 5'(DEV_ADDR_LOW)};
    wire [7:0] shifted  = {sh_ff[6:0], sda};
    wire       last_bit = bit_ff == 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Two-wire slave state machine.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff   <= ST_IDLE;
            ret_ff  <= ST_IDLE;
            sh_ff   <= 8'h00;
            bit_ff  <= 3'h0;
            addr_ff <= 16'h0000;
            ahi_ff  <= 8'h00;
            dhi_ff  <= 8'h00;
            rnw_ff  <= 1'b0;
            drv_ff  <= 1'b0;
            wr_ff   <= 1'b0;
            wdat_ff <= 16'h0000;
            rbuf_ff <= 16'h0000;
        end else if (ce) begin
            wr_ff <= 1'b0;
            if (start_det) begin
                st_ff  <= ST_DEVADR;
                ret_ff <= ST_IDLE;
                bit_ff <= 3'h0;
                drv_ff <= 1'b0;
            end else if (stop_det) begin
                st_ff  <= ST_IDLE;
                ret_ff <= ST_IDLE;
                drv_ff <= 1'b0;
            end else begin
                case (st_ff)
                    ST_IDLE, ST_IGNORE: begin
                        drv_ff <= 1'b0;
                    end
                    ST_DEVADR, ST_ADRHI, ST_ADRLO, ST_WRHI, ST_WRLO: begin
                        if (scl_rise) begin
                            sh_ff  <= shifted;
                            bit_ff <= bit_ff + 3'h1;
                        end
                        if (scl_fall && bit_ff == 3'h0 && sh_ff != 8'h00 && ret_ff == st_ff) begin
                            ret_ff <= ST_IDLE;
                        end
                        if (scl_fall && last_bit == 1'b0 && bit_ff == 3'h0 && ret_ff == ST_BYTEACK) begin
                            ret_ff <= ST_IDLE;
                        end
                        if (scl_rise && last_bit) begin
                            st_ff  <= ST_BYTEACK;
                            ret_ff <= st_ff;
                        end
                    end
                    ST_BYTEACK: begin
                        // Acknowledge is driven from the fall after bit eight until the next fall.
                        if (scl_fall && !drv_ff) begin
                            if (ret_ff == ST_DEVADR && !addr_hit) begin
                                st_ff <= ST_IGNORE;
                            end else begin
                                drv_ff <= 1'b1;
                                case (ret_ff)
                                    ST_DEVADR: rnw_ff <= sh_ff[0];
                                    ST_ADRHI:  ahi_ff <= sh_ff;
                                    ST_ADRLO:  addr_ff <= {ahi_ff, sh_ff};
                                    ST_WRHI:   dhi_ff <= sh_ff;
                                    ST_WRLO: begin
                                        wr_ff   <= 1'b1;
                                        wdat_ff <= {dhi_ff, sh_ff};
                                    end
                                    default: ;
                                endcase
                            end
                        end else if (scl_fall && drv_ff) begin
                            drv_ff <= 1'b0;
                            bit_ff <= 3'h0;
                            case (ret_ff)
                                ST_DEVADR: begin
                                    st_ff   <= rnw_ff ? ST_RDHI : ST_ADRHI;
                                    rbuf_ff <= bus.rd_data;
                                    drv_ff  <= rnw_ff & ~bus.rd_data[15];
                                end
                                ST_ADRHI: st_ff <= ST_ADRLO;
                                ST_ADRLO: st_ff <= ST_WRHI;
                                ST_WRHI:  st_ff <= ST_WRLO;
                                ST_WRLO: begin
                                    st_ff   <= ST_WRHI;
                                    addr_ff <= inc_addr(addr_ff);
                                end
                                default: st_ff <= ST_IDLE;
                            endcase
                        end
                    end
                    ST_RDHI, ST_RDLO: begin
                        if (scl_fall) begin
                            bit_ff <= bit_ff + 3'h1;
                            if (last_bit) begin
                                st_ff  <= ST_MACK;
                                ret_ff <= st_ff;
                                drv_ff <= 1'b0;
                            end else begin
                                drv_ff <= ~rbuf_ff[(st_ff == ST_RDHI ? 15 : 7) - 32'(bit_ff) - 1];
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise && sda) begin
                            st_ff  <= ST_IGNORE;
                            ret_ff <= ST_IDLE;
                            if (ret_ff == ST_RDLO) begin
                                addr_ff <= inc_addr(addr_ff);
                            end
                        end else if (scl_rise) begin
                            sh_ff <= 8'h01;
                        end
                        if (scl_fall && sh_ff == 8'h01) begin
                            sh_ff  <= 8'h00;
                            bit_ff <= 3'h0;
                            if (ret_ff == ST_RDHI) begin
                                st_ff  <= ST_RDLO;
                                drv_ff <= ~rbuf_ff[7];
                            end else begin
                                addr_ff <= inc_addr(addr_ff);
                                st_ff   <= ST_IDLE;
                                ret_ff  <= ST_RDLO;
                            end
                        end
                    end
                    default: st_ff <= ST_IDLE;
                endcase
                // Next word of a continuing read waits two cycles: one for the stepped address to reach
                // the memory and one for its registered read data, else the old word is sent again.
                if (st_ff == ST_IDLE && ret_ff == ST_RDLO) begin
                    ret_ff <= ST_RDHI;
                end else if (st_ff == ST_IDLE && ret_ff == ST_RDHI) begin
                    st_ff   <= ST_RDHI;
                    ret_ff  <= ST_IDLE;
                    rbuf_ff <= bus.rd_data;
                    drv_ff  <= ~bus.rd_data[15];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes from either bus and the mute word.
    wire        any_wr   = spi_mode ? spi_valid : wr_ff;
    wire [15:0] any_addr = spi_mode ? spi_addr : addr_ff;
    wire [15:0] any_data = spi_mode ? spi_data : wdat_ff;
    logic [15:0] mute_ff;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mute_ff <= MUTE_RESET;
        end else if (ce && any_wr && any_addr == MUTE_REG) begin
            mute_ff <= any_data;
        end
    end

    assign bus.wr_en   = ce & any_wr;
    assign bus.wr_addr = any_addr;
    assign bus.wr_data = any_data;
    assign bus.rd_addr = addr_ff;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_data_oe  <= 1'b0;
            ctrl_data_out <= 1'b0;
        end else if (ce) begin
            ctrl_data_oe  <= drv_ff & ~spi_mode;
            ctrl_data_out <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_level_output_mute <= 1'b1;
            headphone_output_mute  <= 1'b1;
            serial_audio_out_mute  <= 1'b1;
        end else if (ce) begin
            line_level_output_mute <= mute_ff[MUTE_LO_BIT];
            headphone_output_mute  <= mute_ff[MUTE_HP_BIT];
            serial_audio_out_mute  <= mute_ff[MUTE_I2S_BIT];
        end
    end
endmodule : codec_control_port

// ==== ccp_sva.sv ====
// Concurrent checks on the pins of the codec control port.
`timescale 1ns/1ps
module ccp_sva (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic mode_pin,
    input wire logic ctrl_clk_pin,
    input wire logic ctrl_data_in,
    input wire logic ctrl_data_out,
    input wire logic ctrl_data_oe,
    input wire logic addr_bit_or_slave_select_pin,
    input wire logic line_level_output_mute,
    input wire logic headphone_output_mute,
    input wire logic serial_audio_out_mute
);
    logic [3:0] fall_cnt_ff;
    logic [3:0] ssr_cnt_ff;
    logic [4:0] high_cnt_ff;
    logic [2:0] mutes;
    assign mutes = {line_level_output_mute, headphone_output_mute, serial_audio_out_mute};

    // Saturating counters give the cycles since the last bus event the pins show.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fall_cnt_ff <= 4'hF;
            ssr_cnt_ff  <= 4'hF;
            high_cnt_ff <= 5'h00;
        end else begin
            fall_cnt_ff <= $fell(ctrl_clk_pin) ? 4'h0 : fall_cnt_ff + {3'h0, fall_cnt_ff != 4'hF};
            ssr_cnt_ff  <= $rose(addr_bit_or_slave_select_pin) ? 4'h0 : ssr_cnt_ff + {3'h0, ssr_cnt_ff != 4'hF};
            high_cnt_ff <= !ctrl_clk_pin ? 5'h00 : high_cnt_ff + {4'h0, high_cnt_ff != 5'h1F};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_mute_in_reset: assert property (disable iff (1'b0) sys_rst |=> mutes == 3'h7 && !ctrl_data_oe)
        else $error("outputs not muted during reset");
    chk_mute_at_release: assert property ($fell(sys_rst) |-> mutes == 3'h7)
        else $error("outputs not muted after reset");
    chk_data_out_zero: assert property (ctrl_data_out == 1'b0)
        else $error("data line driven high");
    chk_spi_no_drive: assert property (mode_pin && $past(mode_pin, 4) |-> !ctrl_data_oe)
        else $error("data line driven in serial-peripheral mode");
    chk_ack_after_fall: assert property ($rose(ctrl_data_oe) |-> fall_cnt_ff inside {[1:7]})
        else $error("data line pulled outside the low clock phase");
    chk_ack_hold_time: assert property ($rose(ctrl_data_oe) |-> ctrl_data_oe [*4])
        else $error("pulled data bit released too early");
    chk_oe_scl_low: assert property ($changed(ctrl_data_oe) |-> !ctrl_clk_pin)
        else $error("data line changed while clock high");
    chk_idle_release: assert property (high_cnt_ff > 5'h0C |-> !ctrl_data_oe)
        else $error("data line held on an idle bus");
    chk_spi_write_slot: assert property (mode_pin && $changed(mutes) |-> ssr_cnt_ff < 4'hC)
        else $error("mute change not tied to a select rise");

    cover property (mutes == 3'h0);
    cover property ($rose(ctrl_data_oe) && !mode_pin);
    cover property (mode_pin && $changed(mutes));
endmodule : ccp_sva

// ==== ccp_host_model.sv ====
// Host controller model that masters the two-wire and serial-peripheral buses.
`timescale 1ns/1ps
module ccp_host_model (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_rel,
    output logic      sel_pin
);
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
        sel_pin = 1'b0;
    end

    // Half a bus period of 80 ns; every change lands 1 ns after a clock edge.
    task automatic hp();
        repeat (8) @(posedge ref_clk);
        #1;
    endtask : hp

    task automatic set_sel(input logic b);
        sel_pin = b;
    endtask : set_sel

    // start while clock high, also used as repeated start
    task automatic start();
        sda_rel = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_rel = 1'b0;
        hp();
        scl = 1'b0;
    endtask : start

    task automatic stop();
        sda_rel = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_rel = 1'b1;
        hp();
    endtask : stop

    // eight bits most significant first, then the acknowledge slot
    task automatic xfer(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_rel = w[i];
            hp();
            scl = 1'b1;
            hp();
            r[i] = sda;
            scl = 1'b0;
        end
    endtask : xfer

    // select low, bits on rising clock, select high; clock rests low
    task automatic spi(input logic [31:0] v, input int n);
        scl = 1'b0;
        hp();
        sel_pin = 1'b0;
        for (int i = 0; i < n; i++) begin
            sda_rel = v[31-i];
            hp();
            scl = 1'b1;
            hp();
            scl = 1'b0;
        end
        hp();
        sel_pin = 1'b1;
        hp();
        sda_rel = ~sda_rel;
    endtask : spi
endmodule : ccp_host_model

// ==== codec_control_port_tb_top.sv ====
// Self-checking bench of the codec control port against a host controller model.
`timescale 1ns/1ps
module codec_control_port_tb_top;
    import ccp_pkg::*;
    logic        ref_clk  = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        ce       = 1'b1;
    logic        mode_pin = 1'b0;
    logic        scl;
    logic        sda_rel;
    logic        sel_pin;
    logic        oe;
    logic [2:0]  mutes;
    logic [15:0] lfsr_st  = 16'h0004;
    logic [15:0] mem [256];
    logic [15:0] wbuf [4];
    logic [15:0] rbuf [4];
    logic [15:0] cur;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc_cnt   = 0;
    wire         sda = sda_rel & ~oe;

    always #5 ref_clk = ~ref_clk;

    codec_control_port codec_control_port_inst (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .mode_pin(mode_pin), .ctrl_clk_pin(scl),
        .ctrl_data_in(sda), .ctrl_data_out(), .ctrl_data_oe(oe), .addr_bit_or_slave_select_pin(sel_pin),
        .line_level_output_mute(mutes[2]), .headphone_output_mute(mutes[1]), .serial_audio_out_mute(mutes[0]));

    ccp_host_model ccp_host_model_inst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel), .sel_pin(sel_pin));

    ////////////////////////////////////////////////////////////////////////////////
    function logic [15:0] rnd();
        lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st;
    endfunction : rnd

    function automatic logic [15:0] exp_mute(input logic [15:0] d);
        return {13'h0000, d[8], d[4], d[0]};
    endfunction : exp_mute

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // Sends the address and nbytes bytes of wbuf; fewer than a full pair leaves a command cut short.
    task automatic i2c_wr(input logic [7:0] dev, input logic [15:0] a, input int nbytes, output logic acked);
        logic [8:0] r;
        logic [7:0] b;
        ccp_host_model_inst.start();
        ccp_host_model_inst.xfer({dev, 1'b1}, r);
        acked = ~r[0];
        for (int i = 0; i < nbytes + 2; i++) begin
            b = (i == 0) ? a[15:8] : (i == 1) ? a[7:0] : (i[0] ? wbuf[(i-2)/2][7:0] : wbuf[(i-2)/2][15:8]);
            ccp_host_model_inst.xfer({b, 1'b1}, r);
            acked = acked & ~r[0];
        end
        ccp_host_model_inst.stop();
    endtask : i2c_wr

    task automatic i2c_rd(input logic [7:0] dev, input logic [15:0] a, input logic new_addr, input int nw);
        logic [8:0] r;
        if (new_addr) begin
            ccp_host_model_inst.start();
            ccp_host_model_inst.xfer({dev, 1'b1}, r);
            ccp_host_model_inst.xfer({a[15:8], 1'b1}, r);
            ccp_host_model_inst.xfer({a[7:0], 1'b1}, r);
            cur = a;
        end
        ccp_host_model_inst.start();
        ccp_host_model_inst.xfer({dev | 8'h01, 1'b1}, r);
        for (int i = 0; i < 2 * nw; i++) begin
            ccp_host_model_inst.xfer({8'hFF, i == 2 * nw - 1}, r);
            rbuf[i/2] = i[0] ? {rbuf[i/2][15:8], r[8:1]} : {r[8:1], 8'h00};
        end
        ccp_host_model_inst.stop();
        for (int k = 0; k < nw; k++) begin
            chk("rd_word", mem[cur[7:0]], rbuf[k]);
            cur = cur + 16'h0001;
        end
    endtask : i2c_rd

    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 60000) begin
            error_cnt = error_cnt + 1;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] d;
        logic        ak;
        logic [7:0]  dev;
        repeat (2) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        mem[8'h24] = MUTE_RESET;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("mute_rst", 16'h0007, {13'h0000, mutes});
        for (int n = 0; n < 2; n++) begin
            ccp_host_model_inst.set_sel(n[0]);
            dev = 8'h14 | {1'b0, n[0], 6'h00};
            wbuf[0] = rnd();
            i2c_wr(dev, MUTE_REG, 2, ak);
            mem[8'h24] = wbuf[0];
            chk("ack", 16'h0001, {15'h0000, ak});
            chk("mutes", exp_mute(wbuf[0]), {13'h0000, mutes});
            wbuf[0] = ~wbuf[0];
            i2c_wr(dev ^ 8'h40, MUTE_REG, 2, ak);
            chk("nack", 16'h0000, {15'h0000, ak});
            chk("mutes_kept", exp_mute(mem[8'h24]), {13'h0000, mutes});
            i2c_rd(dev, MUTE_REG, 1'b1, 1);
        end
        for (int i = 0; i < 4; i++) begin
            wbuf[i] = rnd();
            mem[8'h40 + i[7:0]] = wbuf[i];
        end
        i2c_wr(dev, 16'h0040, 8, ak);
        i2c_rd(dev, 16'h0040, 1'b1, 3);
        i2c_rd(dev, 16'h0000, 1'b0, 1);
        wbuf[0] = ~mem[8'h24];
        i2c_wr(dev, MUTE_REG, 1, ak);
        chk("abort", exp_mute(mem[8'h24]), {13'h0000, mutes});
        // Clearing one field by read, mask and write back keeps the other mutes as they were.
        i2c_rd(dev, MUTE_REG, 1'b1, 1);
        wbuf[0] = rbuf[0] & 16'hFFEF;
        i2c_wr(dev, MUTE_REG, 2, ak);
        mem[8'h24] = wbuf[0];
        chk("rmw", exp_mute(wbuf[0]), {13'h0000, mutes});
        ccp_host_model_inst.set_sel(1'b1);
        mode_pin = 1'b1;
        for (int k = 0; k < 3; k++) begin
            d = rnd();
            ccp_host_model_inst.spi({MUTE_REG, d}, 32);
            chk("spi_mutes", exp_mute(d), {13'h0000, mutes});
            ccp_host_model_inst.spi({MUTE_REG, ~d}, 31);
            chk("spi_short", exp_mute(d), {13'h0000, mutes});
        end
        // With the clock enable low the port samples nothing, so this frame must not land.
        ce = 1'b0;
        ccp_host_model_inst.spi({MUTE_REG, ~d}, 32);
        ce = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("ce_frozen", exp_mute(d), {13'h0000, mutes});
        sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("mute_rerst", 16'h0007, {13'h0000, mutes});
        sys_rst = 1'b0;
        report_and_stop();
    end
endmodule : codec_control_port_tb_top

bind codec_control_port ccp_sva ccp_sva_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .mode_pin(mode_pin), .ctrl_clk_pin(ctrl_clk_pin),
    .ctrl_data_in(ctrl_data_in), .ctrl_data_out(ctrl_data_out), .ctrl_data_oe(ctrl_data_oe),
    .addr_bit_or_slave_select_pin(addr_bit_or_slave_select_pin), .line_level_output_mute(line_level_output_mute),
    .headphone_output_mute(headphone_output_mute), .serial_audio_out_mute(serial_audio_out_mute));
